// ===== pscki_top.sv
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
module pscki_top #(
  parameter int DM_WORDS = 2048
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Memory unit straps and console presence
  input wire logic mem_write_protect,
  input wire logic mem_is_rom,
  input wire logic console_attached,
  // Console key stream
  output logic [7:0] key_code,
  output logic key_valid,
  output logic console_reset,
  // System state
  output logic fault_indicator,
  output logic backup_valid_flag,
  output logic [7:0] sys_options
);
  typedef enum logic [2:0] {
    S_IDLE, S_LOAD, S_BACKUP, S_CLEAR, S_SUM
  } pscki_st_t;

  pscki_key_if kif ();

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [15:0] param_r [30];
  logic [15:0] backup_r [30];
  logic [15:0] sysp_r [30];
  logic [15:0] kword_r [16];

  pscki_st_t st_r, st_nxt;
  logic [4:0] idx_r, idx_nxt;
  logic [4:0] hi_r, hi_nxt;
  logic sum_bk_r, sum_bk_nxt;
  logic [15:0] acc_r, acc_nxt;
  logic [15:0] sum_r, sum_nxt;
  logic [15:0] bsum_r, bsum_nxt;
  logic fault_r, fault_nxt;
  logic bvalid_r, bvalid_nxt;
  logic ben_r, ben_nxt;
  logic [7:0] opts_r, opts_nxt;
  logic kstart_r, kstart_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [2:0] sync1_r, sync2_r;

  logic p_we, s_we, b_we, k_we;
  logic [4:0] p_widx, k_widx;
  logic [15:0] p_wdata, s_wdata, k_wdata;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
    end else begin
      sync1_r <= {console_attached, mem_is_rom, mem_write_protect};
      sync2_r <= sync1_r;
    end
  end

  logic wp_s, rom_s, cons_s;
  assign wp_s = sync2_r[0];
  assign rom_s = sync2_r[1];
  assign cons_s = sync2_r[2];

  function automatic logic in_area(input logic [11:0] a,
                                   input logic [11:0] base,
                                   input int n);
    return a[11:7] == base[11:7] && a[1:0] == 2'b00 &&
      int'(a[6:2]) < n;
  endfunction : in_area

  // ----------------------------------------
  // APB access and command decode
  // ----------------------------------------
  logic acc_go, wr_go, rd_go, busy;
  logic [4:0] aidx;
  logic [7:0] sel_hi, code_lo;
  logic [15:0] ksrc;
  logic [13:0] kaddr;
  logic [14:0] kend;

  assign acc_go = psel && penable && !pready_r;
  assign wr_go = acc_go && pwrite;
  assign rd_go = acc_go && !pwrite;
  assign busy = (st_r != S_IDLE);
  assign aidx = paddr[6:2];
  assign sel_hi = pwdata[15:8];
  assign code_lo = pwdata[7:0];
  assign ksrc = pwdata[15:0];
  assign kaddr = ksrc[pscki_pkg::KS_IND_BIT] ?
    pscki_pkg::bcd_to_bin({2'b00, ksrc[13:0]}) :
    ksrc[13:0];
  assign kend = {1'b0, kaddr} + 15'(pscki_pkg::KEY_WORDS - 1);

  // Read path
  always_comb begin
    prdata_nxt = 32'h0000_0000;
    pslverr_nxt = 1'b0;
    pready_nxt = acc_go;
    if (in_area(paddr, pscki_pkg::KWORD_BASE, pscki_pkg::KEY_WORDS)) begin
      prdata_nxt = {16'h0000, kword_r[aidx[3:0]]};
    end else if (in_area(paddr, pscki_pkg::PARAM_BASE,
                         pscki_pkg::PARAM_WORDS)) begin
      prdata_nxt = {16'h0000, param_r[aidx]};
    end else if (in_area(paddr, pscki_pkg::BACKUP_BASE,
                         pscki_pkg::PARAM_WORDS)) begin
      prdata_nxt = {16'h0000, backup_r[aidx]};
      pslverr_nxt = acc_go && pwrite;
    end else if (in_area(paddr, pscki_pkg::SYSP_BASE,
                         pscki_pkg::PARAM_WORDS)) begin
      prdata_nxt = {16'h0000, sysp_r[aidx]};
      pslverr_nxt = acc_go && pwrite;
    end else begin
      unique case (paddr)
        pscki_pkg::CMD_OFS, pscki_pkg::KEY_OFS: prdata_nxt = 32'h0000_0000;
        pscki_pkg::STAT_OFS: begin
          prdata_nxt[pscki_pkg::ST_FAULT] = fault_r;
          prdata_nxt[pscki_pkg::ST_BVALID] = bvalid_r;
          prdata_nxt[pscki_pkg::ST_BEN] = ben_r;
          prdata_nxt[pscki_pkg::ST_BUSY] = busy;
          prdata_nxt[pscki_pkg::ST_KBUSY] = kif.busy;
        end
        pscki_pkg::OPTS_OFS: prdata_nxt = {24'h000000, opts_r};
        pscki_pkg::SUM_OFS: prdata_nxt = {16'h0000, sum_r};
        pscki_pkg::BSUM_OFS: prdata_nxt = {16'h0000, bsum_r};
        default: pslverr_nxt = acc_go;
      endcase
    end
    if (!rd_go) begin
      prdata_nxt = prdata_r;
    end
  end

  // Control and walk state
  always_comb begin
    st_nxt = st_r;
    idx_nxt = idx_r;
    hi_nxt = hi_r;
    sum_bk_nxt = sum_bk_r;
    acc_nxt = acc_r;
    sum_nxt = sum_r;
    bsum_nxt = bsum_r;
    fault_nxt = fault_r;
    bvalid_nxt = bvalid_r;
    ben_nxt = ben_r;
    opts_nxt = opts_r;
    kstart_nxt = 1'b0;
    p_we = 1'b0;
    p_widx = aidx;
    p_wdata = pwdata[15:0];
    s_we = 1'b0;
    s_wdata = pscki_pkg::PARAM_DEFAULT;
    b_we = 1'b0;
    k_we = 1'b0;
    k_widx = aidx;
    k_wdata = pwdata[15:0];
    unique case (st_r)
      S_IDLE: begin
        // Busy engine ignores new commands and area writes
        if (wr_go && paddr == pscki_pkg::CMD_OFS) begin
          fault_nxt = 1'b0;
          if (sel_hi == pscki_pkg::SEL_CMD) begin // see (R1)
            idx_nxt = pscki_pkg::ALL_LO;
            hi_nxt = pscki_pkg::ALL_HI;
            unique case (code_lo)
              pscki_pkg::CMD_NOP: ;
              pscki_pkg::CMD_SET: st_nxt = S_LOAD; // see (R3)
              pscki_pkg::CMD_GEN: begin
                st_nxt = S_LOAD;
                hi_nxt = pscki_pkg::GEN_HI; // see (R8)
              end
              pscki_pkg::CMD_HSC: begin
                st_nxt = S_LOAD;
                idx_nxt = pscki_pkg::HSC_LO; // see (R9)
                hi_nxt = pscki_pkg::HSC_HI;
              end
              pscki_pkg::CMD_SER: begin
                st_nxt = S_LOAD;
                idx_nxt = pscki_pkg::SER_LO; // see (R10)
              end
              pscki_pkg::CMD_BACKUP: begin
                if (wp_s || rom_s) begin
                  fault_nxt = 1'b1; // see (R5) see (R19)
                end else begin
                  st_nxt = S_BACKUP; // see (R4)
                end
              end
              pscki_pkg::CMD_BDIS: begin
                ben_nxt = 1'b0; // see (R6)
                bvalid_nxt = 1'b0;
              end
              pscki_pkg::CMD_CLEAR: st_nxt = S_CLEAR; // see (R7)
              default: fault_nxt = 1'b1; // see (R11) see (R19)
            endcase
          end else if (sel_hi == pscki_pkg::SEL_BITS) begin
            opts_nxt = code_lo & pscki_pkg::OPT_MASK; // see (R2)
          end else begin
            fault_nxt = 1'b1; // see (R19)
          end
        end else if (wr_go && paddr == pscki_pkg::KEY_OFS) begin
          fault_nxt = 1'b0;
          if (kif.busy || !cons_s) begin
            fault_nxt = 1'b1; // see (R17) see (R19)
          end else if (ksrc[pscki_pkg::KS_IND_BIT] &&
                       !pscki_pkg::is_bcd({2'b00, ksrc[13:0]})) begin
            fault_nxt = 1'b1; // see (R18)
          end else if (int'(kend) > DM_WORDS - 1) begin
            fault_nxt = 1'b1; // see (R17) see (R18)
          end else begin
            kstart_nxt = 1'b1; // see (R12)
          end
        end else if (wr_go && in_area(paddr, pscki_pkg::PARAM_BASE,
                                      pscki_pkg::PARAM_WORDS)) begin
          p_we = 1'b1;
        end else if (wr_go && !kif.busy &&
                     in_area(paddr, pscki_pkg::KWORD_BASE,
                             pscki_pkg::KEY_WORDS)) begin
          k_we = 1'b1;
        end
      end
      S_LOAD: begin
        s_we = 1'b1;
        s_wdata = pscki_pkg::is_bcd(param_r[idx_r]) ? param_r[idx_r] :
          pscki_pkg::PARAM_DEFAULT; // see (R3)
        if (idx_r == hi_r) begin
          st_nxt = S_SUM;
          sum_bk_nxt = 1'b0;
          idx_nxt = pscki_pkg::ALL_LO;
          acc_nxt = 16'h0000;
        end else begin
          idx_nxt = idx_r + 5'h01;
        end
      end
      S_BACKUP: begin
        b_we = 1'b1; // see (R4)
        if (idx_r == pscki_pkg::ALL_HI) begin
          st_nxt = S_SUM;
          sum_bk_nxt = 1'b1;
          idx_nxt = pscki_pkg::ALL_LO;
          acc_nxt = 16'h0000;
        end else begin
          idx_nxt = idx_r + 5'h01;
        end
      end
      S_CLEAR: begin
        p_we = 1'b1;
        p_widx = idx_r;
        p_wdata = 16'h0000; // see (R7)
        if (idx_r == pscki_pkg::ALL_HI) begin
          st_nxt = S_IDLE;
        end else begin
          idx_nxt = idx_r + 5'h01;
        end
      end
      S_SUM: begin
        acc_nxt = acc_r + (sum_bk_r ? backup_r[idx_r] : sysp_r[idx_r]);
        if (idx_r == pscki_pkg::ALL_HI) begin
          st_nxt = S_IDLE;
          if (sum_bk_r) begin
            bsum_nxt = acc_nxt; // see (R4)
            ben_nxt = 1'b1;
            bvalid_nxt = 1'b1;
          end else begin
            sum_nxt = acc_nxt; // see (R3)
          end
        end else begin
          idx_nxt = idx_r + 5'h01;
        end
      end
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= S_IDLE;
      idx_r <= 5'h00;
      hi_r <= 5'h00;
      sum_bk_r <= 1'b0;
      acc_r <= 16'h0000;
      sum_r <= 16'h0000;
      bsum_r <= 16'h0000;
      fault_r <= 1'b0;
      bvalid_r <= 1'b0;
      ben_r <= 1'b0;
      opts_r <= 8'h00;
      kstart_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      idx_r <= idx_nxt;
      hi_r <= hi_nxt;
      sum_bk_r <= sum_bk_nxt;
      acc_r <= acc_nxt;
      sum_r <= sum_nxt;
      bsum_r <= bsum_nxt;
      fault_r <= fault_nxt;
      bvalid_r <= bvalid_nxt;
      ben_r <= ben_nxt;
      opts_r <= opts_nxt;
      kstart_r <= kstart_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Memories: written only through the strobes above
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < pscki_pkg::PARAM_WORDS; i++) begin
        param_r[i] <= 16'h0000;
        backup_r[i] <= 16'h0000;
        sysp_r[i] <= pscki_pkg::PARAM_DEFAULT;
      end
      for (int i = 0; i < pscki_pkg::KEY_WORDS; i++) begin
        kword_r[i] <= 16'h0000;
      end
    end else begin
      if (p_we) begin
        param_r[p_widx] <= p_wdata;
      end
      if (s_we) begin
        sysp_r[idx_r] <= s_wdata;
      end
      if (b_we) begin
        backup_r[idx_r] <= param_r[idx_r];
      end
      if (k_we) begin
        kword_r[k_widx[3:0]] <= k_wdata;
      end
    end
  end

  // ----------------------------------------
  // Key sequencer
  // ----------------------------------------
  assign kif.start = kstart_r;
  assign kif.words = kword_r;

  pscki_key_seq u_key_seq (
    .clk(clk),
    .rst(rst),
    .kif(kif),
    .key_code(key_code),
    .key_valid(key_valid),
    .console_reset(console_reset)
  );

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign fault_indicator = fault_r;
  assign backup_valid_flag = bvalid_r;
  assign sys_options = opts_r;
endmodule : pscki_top

// ===== pscki_pkg.sv
// Notes on behaviour
// (R1) Upper byte zero: run system command code
// (R2) Upper byte A3: set operating option bits
// (R3) Code 01: load, validate, default, checksum all
// (R4) Code 02: copy to backup, checksum, flag
// (R5) Backup refused when memory protected or ROM
// (R6) Code 03: disable backup, clear flag
// (R7) Code 04: zero every parameter word
// (R8) Code 05: full load of words 0-5
// (R9) Code 06: full load of words 5-19
// (R10) Code 07: full load of words 20-29
// (R11) Unknown code under zero selector raises fault
// (R12) Each key code acts as console press
// (R13) Upper byte first, then lower, next word
// (R14) At most 32 codes; null code stops
// (R15) Reset code returns console initial display
// (R16) Program keeps range, inhibit clear, console attached
// (R17) Fault on area crossing or missing console
// (R18) Fault on non-BCD or out-of-range pointer
// (R19) Faulted request changes nothing at all
package pscki_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] CMD_OFS = 12'h000;
  localparam logic [11:0] KEY_OFS = 12'h004;
  localparam logic [11:0] STAT_OFS = 12'h008;
  localparam logic [11:0] OPTS_OFS = 12'h00c;
  localparam logic [11:0] SUM_OFS = 12'h010;
  localparam logic [11:0] BSUM_OFS = 12'h014;
  localparam logic [11:0] KWORD_BASE = 12'h080;
  localparam logic [11:0] PARAM_BASE = 12'h100;
  localparam logic [11:0] BACKUP_BASE = 12'h200;
  localparam logic [11:0] SYSP_BASE = 12'h300;
  // ----------------------------------------
  // Sizes and fields
  // ----------------------------------------
  localparam int PARAM_WORDS = 30;
  localparam int KEY_WORDS = 16;
  localparam logic [4:0] KEY_LAST_IDX = 5'h1f;
  localparam logic [7:0] SEL_CMD = 8'h00;
  localparam logic [7:0] SEL_BITS = 8'ha3;
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_SET = 8'h01;
  localparam logic [7:0] CMD_BACKUP = 8'h02;
  localparam logic [7:0] CMD_BDIS = 8'h03;
  localparam logic [7:0] CMD_CLEAR = 8'h04;
  localparam logic [7:0] CMD_GEN = 8'h05;
  localparam logic [7:0] CMD_HSC = 8'h06;
  localparam logic [7:0] CMD_SER = 8'h07;
  localparam logic [4:0] ALL_LO = 5'h00;
  localparam logic [4:0] ALL_HI = 5'h1d;
  localparam logic [4:0] GEN_HI = 5'h05;
  localparam logic [4:0] HSC_LO = 5'h05;
  localparam logic [4:0] HSC_HI = 5'h13;
  localparam logic [4:0] SER_LO = 5'h14;
  localparam logic [7:0] OPT_MASK = 8'hc1;
  localparam logic [7:0] KEY_NULL = 8'h00;
  localparam logic [7:0] KEY_RESET = 8'h40;
  localparam int KS_IND_BIT = 15;
  localparam int ST_FAULT = 0;
  localparam int ST_BVALID = 1;
  localparam int ST_BEN = 2;
  localparam int ST_BUSY = 3;
  localparam int ST_KBUSY = 4;
  localparam logic [15:0] PARAM_DEFAULT = 16'h0000;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int KEY_GAP_NS = 100;
  localparam int KEY_GAP_CYC = (KEY_GAP_NS * CLK_MHZ) / 1000;

  function automatic logic is_bcd(input logic [15:0] v);
    return v[3:0] < 4'ha && v[7:4] < 4'ha && v[11:8] < 4'ha &&
      v[15:12] < 4'ha;
  endfunction : is_bcd

  function automatic logic [13:0] bcd_to_bin(input logic [15:0] v);
    logic [15:0] s;
    s = 16'(v[15:12]) * 16'd1000 + 16'(v[11:8]) * 16'd100 +
      16'(v[7:4]) * 16'd10 + 16'(v[3:0]);
    return s[13:0];
  endfunction : bcd_to_bin
endpackage : pscki_pkg

// ===== pscki_key_if.sv
`timescale 1ns/1ps
interface pscki_key_if;
  logic start;
  logic [15:0] words [16];
  logic busy;
  modport ctl (output start, output words, input busy);
  modport seq (input start, input words, output busy);
endinterface : pscki_key_if

// ===== pscki_key_seq.sv
`timescale 1ns/1ps
module pscki_key_seq (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request from the command side
  pscki_key_if.seq kif,
  // Console
  output logic [7:0] key_code,
  output logic key_valid,
  output logic console_reset
);
  typedef enum logic {K_IDLE, K_RUN} pscki_kst_t;
  pscki_kst_t st_r, st_nxt;
  logic [15:0] w_r [16];
  logic [4:0] idx_r, idx_nxt;
  logic [7:0] gap_r, gap_nxt;
  logic [7:0] code_r, code_nxt;
  logic kv_r, kv_nxt, cr_r, cr_nxt;
  logic [7:0] cur;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    idx_nxt = idx_r;
    gap_nxt = gap_r;
    code_nxt = code_r;
    kv_nxt = 1'b0;
    cr_nxt = 1'b0;
    cur = idx_r[0] ? w_r[idx_r[4:1]][7:0] : w_r[idx_r[4:1]][15:8]; // see (R13)
    unique case (st_r)
      K_IDLE: begin
        if (kif.start) begin
          st_nxt = K_RUN;
          idx_nxt = 5'h00;
          gap_nxt = 8'(pscki_pkg::KEY_GAP_CYC - 1);
        end
      end
      K_RUN: begin
        // Paced so the console can digest each press
        if (gap_r != 8'h00) begin
          gap_nxt = gap_r - 8'h01;
        end else if (cur == pscki_pkg::KEY_NULL) begin
          st_nxt = K_IDLE; // see (R14)
        end else begin
          code_nxt = cur;
          kv_nxt = 1'b1; // see (R12)
          cr_nxt = (cur == pscki_pkg::KEY_RESET); // see (R15)
          gap_nxt = 8'(pscki_pkg::KEY_GAP_CYC - 1);
          if (idx_r == pscki_pkg::KEY_LAST_IDX) begin
            st_nxt = K_IDLE; // see (R14)
          end else begin
            idx_nxt = idx_r + 5'h01;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= K_IDLE;
      idx_r <= 5'h00;
      gap_r <= 8'h00;
      code_r <= 8'h00;
      kv_r <= 1'b0;
      cr_r <= 1'b0;
      for (int i = 0; i < pscki_pkg::KEY_WORDS; i++) begin
        w_r[i] <= 16'h0000;
      end
    end else begin
      st_r <= st_nxt;
      idx_r <= idx_nxt;
      gap_r <= gap_nxt;
      code_r <= code_nxt;
      kv_r <= kv_nxt;
      cr_r <= cr_nxt;
      if (st_r == K_IDLE && kif.start) begin
        w_r <= kif.words;
      end
    end
  end

  assign kif.busy = (st_r == K_RUN);
  assign key_code = code_r;
  assign key_valid = kv_r;
  assign console_reset = cr_r;
endmodule : pscki_key_seq

// ===== pscki_checker.sv
`timescale 1ns/1ps
module pscki_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Console and state
  input wire logic [7:0] key_code,
  input wire logic key_valid,
  input wire logic console_reset,
  input wire logic fault_indicator,
  input wire logic [7:0] sys_options
);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  chk_one_wait_state: assert property (
    psel && penable && !pready |=> pready) else $error("pready late");
  chk_ready_pulse: assert property (
    pready |=> !pready) else $error("pready held");
  chk_err_with_ready: assert property (
    pslverr |-> pready) else $error("pslverr alone");
  chk_fault_on_access: assert property (
    $changed(fault_indicator) |-> pready) else $error("fault moved");
  chk_option_bits: assert property (
    $changed(sys_options) |-> pready && (sys_options & 8'h3e) == 8'h00)
    else $error("options bad");
  chk_reset_code: assert property (
    console_reset |-> key_valid && key_code == 8'h40)
    else $error("reset pulse bad");
  chk_no_null_key: assert property (
    key_valid |-> key_code != 8'h00) else $error("null emitted");
  chk_key_spacing: assert property (
    key_valid |=> !key_valid [*8]) else $error("keys too close");
  chk_code_holds: assert property (
    $changed(key_code) |-> key_valid) else $error("key code moved");

  cov_key: cover property (key_valid);
  cov_home: cover property (console_reset);
  cov_err: cover property (pslverr);
  cov_fault: cover property ($rose(fault_indicator));
endmodule : pscki_checker

bind pscki_top pscki_checker u_chk (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .key_code(key_code), .key_valid(key_valid),
  .console_reset(console_reset), .fault_indicator(fault_indicator),
  .sys_options(sys_options)
);

// ===== pscki_console_model.sv
`timescale 1ns/1ps
module pscki_console_model (
  // Clock
  input wire logic clk,
  // Key stream
  input wire logic [7:0] key_code,
  input wire logic key_valid,
  input wire logic console_reset,
  // Presence
  input wire logic plug,
  output logic console_attached,
  output int presses
);
  // ----------------------------------------
  // Console
  // ----------------------------------------
  // Program keeps the console mounted unless a test unplugs it
  assign console_attached = plug;
  always @(posedge clk) begin
    if (key_valid === 1'b1) begin
      presses <= presses + 1;
    end
  end
endmodule : pscki_console_model

// ===== pscki_tb_top.sv
`timescale 1ns/1ps
module pscki_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic pready, pslverr, key_valid, console_reset, fault, bvalid;
  logic wp = 1'b0, rom = 1'b0, plug = 1'b1;
  logic [7:0] key_code, sys_options;
  logic console_attached;
  int presses;
  int failures = 0, checks = 0;
  logic [31:0] qd[$], qm[$];
  logic qe[$];
  logic [7:0] qk[$];
  logic [15:0] par[30], sysw[30];

  always #2.5 clk = ~clk;

  pscki_top #(.DM_WORDS(2048)) dut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_write_protect(wp), .mem_is_rom(rom),
    .console_attached(console_attached), .key_code(key_code),
    .key_valid(key_valid), .console_reset(console_reset),
    .fault_indicator(fault), .backup_valid_flag(bvalid),
    .sys_options(sys_options));
  pscki_console_model u_con (
    .clk(clk), .key_code(key_code), .key_valid(key_valid),
    .console_reset(console_reset), .plug(plug),
    .console_attached(console_attached), .presses(presses));

  // ----------------------------------------
  // Reporting and compares
  // ----------------------------------------
  task automatic bad(input string s);
    failures++;
    $display("BAD %0t %s", $time, s);
  endtask : bad
  task automatic final_report;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task automatic cmp_bus;
    logic [31:0] d, m;
    logic e;
    if (qd.size() == 0) begin
      bad("stray pready");
      return;
    end
    d = qd.pop_front();
    m = qm.pop_front();
    e = qe.pop_front();
    checks++;
    if ((prdata & m) !== (d & m) || pslverr !== e) bad("bus result");
  endtask : cmp_bus
  task automatic cmp_key(input logic [7:0] k);
    if (qk.size() == 0) begin
      bad("stray key");
      return;
    end
    checks++;
    if (k !== qk.pop_front()) bad("key code");
  endtask : cmp_key
  task automatic cmp_cnt(input int got, input int exp);
    checks++;
    if (got != exp) bad("press count");
  endtask : cmp_cnt
  task automatic cmp_flag(input logic got, input logic exp);
    checks++;
    if (got !== exp) bad("flag level");
  endtask : cmp_flag

  always @(posedge clk) if (pready === 1'b1) cmp_bus();
  always @(posedge clk) if (key_valid === 1'b1) cmp_key(key_code);

  // ----------------------------------------
  // Bus master
  // ----------------------------------------
  // One idle cycle between transfers keeps each strobe single-driven
  task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic [31:0] ed, input logic [31:0] em,
      input logic ee);
    qd.push_back(ed);
    qm.push_back(em);
    qe.push_back(ee);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
      input logic e = 1'b0);
    xfer(1'b1, a, d, 32'h0, 32'h0, e);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] d,
      input logic [31:0] m = '1, input logic e = 1'b0);
    xfer(1'b0, a, 32'h0, d, m, e);
  endtask : rd
  task automatic idle(input int b);
    for (int n = 0; n < 400; n++) begin
      xfer(1'b0, pscki_pkg::STAT_OFS, 32'h0, 32'h0, 32'h0, 1'b0);
      if (rdv[b] === 1'b0) break;
    end
  endtask : idle

  // ----------------------------------------
  // Scenario helpers
  // ----------------------------------------
  function automatic logic [15:0] rbcd();
    for (int k = 0; k < 16; k += 4) rbcd[k+:4] = 4'($urandom_range(9));
  endfunction : rbcd
  function automatic logic [15:0] vfix(input logic [15:0] v);
    vfix = v;
    for (int k = 0; k < 16; k += 4)
      if (v[k+:4] > 4'h9) vfix = pscki_pkg::PARAM_DEFAULT;
  endfunction : vfix
  task automatic load(input logic [7:0] c, input int lo, input int hi);
    logic [15:0] s;
    s = 16'h0;
    for (int i = 0; i < 30; i++) begin
      par[i] = i[0] ? 16'($urandom) : rbcd();
      wr(pscki_pkg::PARAM_BASE + 12'(4 * i), {16'h0, par[i]});
    end
    wr(pscki_pkg::CMD_OFS, {24'h0, c});
    idle(3);
    for (int i = 0; i < 30; i++) begin
      if (i >= lo && i <= hi) sysw[i] = vfix(par[i]);
      s = s + sysw[i];
      rd(pscki_pkg::SYSP_BASE + 12'(4 * i), {16'h0, sysw[i]});
    end
    rd(pscki_pkg::SUM_OFS, {16'h0, s});
  endtask : load
  task automatic keys(input int stop);
    logic [15:0] w;
    logic [7:0] c;
    int idx;
    for (int i = 0; i < 16; i++) begin
      for (int h = 0; h < 2; h++) begin
        idx = 2 * i + h;
        c = (idx == 1) ? 8'h40 : 8'($urandom_range(255, 1));
        if (idx == stop) c = 8'h00;
        if (idx < stop) qk.push_back(c);
        w = h ? {w[15:8], c} : {c, 8'h00};
      end
      wr(pscki_pkg::KWORD_BASE + 12'(4 * i), {16'h0, w});
    end
    wr(pscki_pkg::KEY_OFS, 32'h0);
    idle(4);
    rd(pscki_pkg::STAT_OFS, 32'h0, 32'h1);
  endtask : keys

  initial begin
    #400000;
    bad("timeout");
    final_report();
  end

  initial begin
    logic [15:0] s;
    logic [15:0] bc[3];
    logic [15:0] kf[3];
    logic [7:0] c;
    bc = '{16'h0008, 16'h00ff, 16'h5501};
    kf = '{16'h07f1, 16'h80a5, 16'ha040};
    void'($urandom(99));
    foreach (sysw[i]) sysw[i] = 16'h0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(pscki_pkg::STAT_OFS, 32'h0);
    rd(12'h040, 32'h0, '1, 1'b1);
    wr(12'h040, 32'h1, 1'b1);
    load(pscki_pkg::CMD_SET, 0, 29);
    load(pscki_pkg::CMD_GEN, 0, 5);
    load(pscki_pkg::CMD_HSC, 5, 19);
    load(pscki_pkg::CMD_SER, 20, 29);
    wr(pscki_pkg::CMD_OFS, 32'h2);
    idle(3);
    rd(pscki_pkg::STAT_OFS, 32'h6, 32'h7);
    cmp_flag(bvalid, 1'b1);
    s = 16'h0;
    for (int i = 0; i < 30; i++) begin
      s = s + par[i];
      rd(pscki_pkg::BACKUP_BASE + 12'(4 * i), {16'h0, par[i]});
    end
    rd(pscki_pkg::BSUM_OFS, {16'h0, s});
    for (int k = 1; k < 3; k++) begin
      {rom, wp} <= 2'(k);
      repeat (3) @(posedge clk);
      wr(pscki_pkg::PARAM_BASE, {16'h0, ~par[0]});
      wr(pscki_pkg::CMD_OFS, 32'h2);
      rd(pscki_pkg::STAT_OFS, 32'h7, 32'h7);
      rd(pscki_pkg::BACKUP_BASE, {16'h0, par[0]});
    end
    {rom, wp} <= 2'b00;
    wr(pscki_pkg::CMD_OFS, 32'h3);
    rd(pscki_pkg::STAT_OFS, 32'h0, 32'h7);
    cmp_flag(bvalid, 1'b0);
    wr(pscki_pkg::CMD_OFS, 32'h4);
    idle(3);
    for (int i = 0; i < 30; i++)
      rd(pscki_pkg::PARAM_BASE + 12'(4 * i), 32'h0);
    foreach (bc[i]) begin
      wr(pscki_pkg::CMD_OFS, {16'h0, bc[i]});
      rd(pscki_pkg::STAT_OFS, 32'h1, 32'h1);
      cmp_flag(fault, 1'b1);
    end
    wr(pscki_pkg::CMD_OFS, 32'h0);
    rd(pscki_pkg::STAT_OFS, 32'h0, 32'h1);
    c = 8'($urandom) | 8'h01;
    wr(pscki_pkg::CMD_OFS, {16'h0, 8'ha3, c});
    rd(pscki_pkg::OPTS_OFS, {24'h0, c & 8'hc1});
    cmp_flag(sys_options == (c & 8'hc1), 1'b1);
    keys(7);
    keys(32);
    foreach (kf[i]) begin
      wr(pscki_pkg::KEY_OFS, {16'h0, kf[i]});
      rd(pscki_pkg::STAT_OFS, 32'h1, 32'h1);
    end
    plug <= 1'b0;
    repeat (3) @(posedge clk);
    wr(pscki_pkg::KEY_OFS, 32'h0);
    rd(pscki_pkg::STAT_OFS, 32'h1, 32'h1);
    repeat (100) @(posedge clk);
    cmp_cnt(presses, 39);
    final_report();
  end
endmodule : pscki_tb_top
